// file: hdl/gpt_top.sv
// General purpose timer: one A channel, one B channel, APB registers.
// Assumes pclk is the count source and trigger input is synchronous.
`timescale 1ns/1ps
module gpt_top (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic a_trigger_input,
    output logic a_pulse_output,
    // Request flags
    output logic [1:0] interrupt_request_flag
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire hit_start = paddr == gpt_pkg::OFS_START;
    wire hit_amode = paddr == gpt_pkg::OFS_A_MODE;
    wire hit_acnt = paddr == gpt_pkg::OFS_A_CNT;
    wire hit_bmode = paddr == gpt_pkg::OFS_B_MODE;
    wire hit_bcnt = paddr == gpt_pkg::OFS_B_CNT;
    wire hit_updn = paddr == gpt_pkg::OFS_UPDN;
    wire hit_irq = paddr == gpt_pkg::OFS_IRQ;
    wire hit_trig = paddr == gpt_pkg::OFS_TRIG;
    wire mapped = hit_start | hit_amode | hit_acnt | hit_bmode | hit_bcnt | hit_updn
        | hit_irq | hit_trig;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [1:0] count_start_flags_reg; // Start flags, A and B
    logic [2:0] a_channel_mode_reg; // Mode and trigger select
    logic [1:0] b_channel_mode_reg; // Timer or event only
    logic up_down_select_reg; // A count direction
    logic a_mode_seen; // A mode written since reset
    logic a_written_stopped; // A counter written while stopped
    wire [1:0] a_mode = a_channel_mode_reg[1:0];
    wire a_pulse_mode = a_mode == gpt_pkg::MODE_ONESHOT || a_mode == gpt_pkg::MODE_PWM;
    wire [1:0] new_mode = pwdata[1:0];
    wire new_pulse = new_mode == gpt_pkg::MODE_ONESHOT || new_mode == gpt_pkg::MODE_PWM;
    // Entering a pulse mode from reset, timer or event raises the flag
    wire mode_enter = wr & hit_amode & new_pulse & (~a_mode_seen | ~a_pulse_mode);
    wire a_start_wr = wr & hit_start;
    wire a_stop = a_start_wr & ~pwdata[gpt_pkg::BIT_A] & count_start_flags_reg[gpt_pkg::BIT_A];
    wire b_run = count_start_flags_reg[gpt_pkg::BIT_B];

    // Start flags and mode registers; all idle after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_start_flags_reg <= 2'h0;
            a_channel_mode_reg <= 3'h0;
            b_channel_mode_reg <= 2'h0;
            up_down_select_reg <= 1'b0;
            a_mode_seen <= 1'b0;
        end else begin
            if (a_start_wr) begin
                count_start_flags_reg <= pwdata[1:0];
            end
            if (wr && hit_amode) begin
                a_channel_mode_reg <= pwdata[2:0];
                a_mode_seen <= 1'b1;
            end
            if (wr && hit_bmode) begin
                b_channel_mode_reg <= pwdata[1:0];
            end
            if (wr && hit_updn) begin
                up_down_select_reg <= pwdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // A channel: trigger, run state and pulse
    // ------------------------------------------------------------
    logic ext_rise; // External trigger edge
    logic a_active; // One-shot or PWM window in progress
    logic a_pulse; // Drives the output pin
    logic stop_flag_dly; // Flag one cycle after one-shot stop
    logic [15:0] a_count;
    logic [15:0] a_reload;
    logic a_wrap;
    logic a_wrap_up;
    wire a_start = count_start_flags_reg[gpt_pkg::BIT_A];
    wire sw_trig = wr & hit_trig & pwdata[gpt_pkg::BIT_A];
    wire use_ext = a_channel_mode_reg[gpt_pkg::BIT_EXT_TRIG];
    wire trig = a_start & (use_ext ? ext_rise : sw_trig);
    wire is_os = a_mode == gpt_pkg::MODE_ONESHOT;
    wire is_pwm = a_mode == gpt_pkg::MODE_PWM;
    wire retrig = is_os & a_active & trig;
    // One-shot and PWM run only inside their window; timer and event run on start
    wire a_run = a_start & (a_pulse_mode ? a_active : 1'b1);
    wire a_up = (a_mode == gpt_pkg::MODE_EVENT) & up_down_select_reg;
    wire a_reload_now = retrig | (a_stop & is_os);
    wire a_end = a_active & a_wrap;

    gpt_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(a_trigger_input),
        .rise(ext_rise)
    );

    gpt_chan u_a (
        .pclk(pclk),
        .presetn(presetn),
        .run(a_run),
        .up(a_up),
        .wr(wr & hit_acnt),
        .wdata(pwdata[15:0]),
        .reload_now(a_reload_now),
        .count(a_count),
        .reload(a_reload),
        .wrap(a_wrap),
        .wrap_up(a_wrap_up)
    );

    // One-shot and PWM window with pulse output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_active <= 1'b0;
            a_pulse <= 1'b0;
            stop_flag_dly <= 1'b0;
        end else begin
            stop_flag_dly <= a_stop & is_os & a_active;
            if (a_stop || !a_start) begin
                a_active <= 1'b0;
                a_pulse <= 1'b0;
            end else if (trig && a_pulse_mode) begin
                a_active <= 1'b1;
                a_pulse <= 1'b1;
            end else if (is_os && a_end) begin
                a_active <= 1'b0;
                a_pulse <= 1'b0;
            end else if (is_pwm && a_end) begin
                a_pulse <= ~a_pulse;
            end
        end
    end
    assign a_pulse_output = a_pulse;

    // Written-while-stopped marker, dropped once counting begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_written_stopped <= 1'b0;
        end else if (wr && hit_acnt && !a_run) begin
            a_written_stopped <= 1'b1;
        end else if (a_run) begin
            a_written_stopped <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // B channel
    // ------------------------------------------------------------
    logic [15:0] b_count;
    logic b_wrap;
    gpt_chan u_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(b_run),
        .up(1'b0),
        .wr(wr & hit_bcnt),
        .wdata(pwdata[15:0]),
        .reload_now(1'b0),
        .count(b_count),
        .reload(),
        .wrap(b_wrap),
        .wrap_up()
    );

    // ------------------------------------------------------------
    // Request flags: set wins over write-one clear
    // ------------------------------------------------------------
    logic [1:0] next_irq;
    wire pwm_stop_high = a_stop & is_pwm & a_pulse;
    wire a_set = mode_enter | stop_flag_dly | pwm_stop_high | a_wrap;
    wire [1:0] irq_set = {b_wrap, a_set};
    wire [1:0] irq_clr = (wr & hit_irq) ? pwdata[1:0] : 2'h0;
    assign next_irq = (interrupt_request_flag & ~irq_clr) | irq_set;

    // Flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request_flag <= 2'h0;
        end else begin
            interrupt_request_flag <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Reload cycle answers all ones, or zeros after an up overflow
    wire a_ev = a_mode == gpt_pkg::MODE_EVENT;
    wire [15:0] a_rd_live = a_written_stopped ? a_reload : a_count;
    wire [15:0] a_rd = a_wrap ? ((a_ev && a_wrap_up) ? gpt_pkg::CNT_ZERO : gpt_pkg::CNT_ONES)
        : a_rd_live;
    wire [15:0] b_rd = b_wrap ? gpt_pkg::CNT_ONES : b_count;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = gpt_pkg::RD_ZERO;
        if (hit_start) rd_mux = {30'h0, count_start_flags_reg};
        if (hit_amode) rd_mux = {29'h0, a_channel_mode_reg};
        if (hit_acnt) rd_mux = {16'h0, a_rd};
        if (hit_bmode) rd_mux = {30'h0, b_channel_mode_reg};
        if (hit_bcnt) rd_mux = {16'h0, b_rd};
        if (hit_updn) rd_mux = {31'h0, up_down_select_reg};
        if (hit_irq) rd_mux = {30'h0, interrupt_request_flag};
    end

    // Registered read data, loaded during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= gpt_pkg::RD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    stop_pulse_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        a_stop |=> !a_pulse_output) else $error("pulse not low after stop");
    oneshot_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        a_stop && is_os && a_active |=> ##1 interrupt_request_flag[0])
        else $error("one-shot stop flag missing");
    trig_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig && a_pulse_mode && !a_stop |=> a_pulse_output)
        else $error("trigger pulse late");
    enter_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_enter |=> interrupt_request_flag[0]) else $error("mode entry flag");
    reset_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> count_start_flags_reg == 2'h0) else $error("not stopped");
    b_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        b_wrap |-> b_rd == gpt_pkg::CNT_ONES) else $error("b reload read");
    a_wrap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        a_wrap && !$past(wr && hit_acnt) |-> a_count == a_reload)
        else $error("reload missed");
    retrig_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        retrig && !(wr && hit_acnt) |=> a_count == $past(a_reload) && a_active)
        else $error("retrigger reload");
    cov_oneshot: cover property (@(posedge pclk) trig && is_os ##[1:20] a_end);
    cov_pwm_stop: cover property (@(posedge pclk) pwm_stop_high);
    cov_b_wrap: cover property (@(posedge pclk) b_wrap);
endmodule // gpt_top

// file: hdl/gpt_pkg.sv
// Constants for the general purpose timer block: register offsets,
// field positions, reset values, mode codes and timing counts.
// Assumes an APB slave with 32-bit data and 10 MHz pclk.
//
// Operation
// - Channels stopped after reset until start set
// - A timer read gives count, ones during reload
// - A event read ones on underflow, zeros overflow
// - One-shot stop reloads, output low, flag later
// - One-shot output within one count period
// - Entering one-shot mode from reset, timer or event sets request flag
// - Retrigger reloads at once, keeps counting
// - Entering PWM mode from reset, timer or event sets request flag
// - PWM stop drops high output, sets flag
// - B counter read live, ones during reload
package gpt_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_START = 8'h00;    // Start flags, bit 0 A, bit 1 B
    localparam logic [7:0] OFS_A_MODE = 8'h04;   // A channel mode
    localparam logic [7:0] OFS_A_CNT = 8'h08;    // A counter / reload
    localparam logic [7:0] OFS_B_MODE = 8'h0C;   // B channel mode
    localparam logic [7:0] OFS_B_CNT = 8'h10;    // B counter / reload
    localparam logic [7:0] OFS_UPDN = 8'h14;     // A up/down select
    localparam logic [7:0] OFS_IRQ = 8'h18;      // Request flags, write 1 to clear
    localparam logic [7:0] OFS_TRIG = 8'h1C;     // Software trigger, write 1
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_A = 0;
    localparam int BIT_B = 1;
    localparam int BIT_EXT_TRIG = 2;             // A mode: external trigger
    // ------------------------------------------------------------
    // Mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [15:0] CNT_ONES = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int GUARD_NS = 300;                // Late retrigger window
    localparam int GUARD_CYC = (GUARD_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: hdl/gpt_edge.sv
// Rising edge detector for a synchronous input.
// Assumes the input is already in the pclk domain.
`timescale 1ns/1ps
module gpt_edge (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in, pulse out
    input wire logic level,
    output logic rise
);
    logic last; // Previous sample

    // Sample history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
        end else begin
            last <= level;
        end
    end

    assign rise = level & ~last;
endmodule // gpt_edge

// file: hdl/gpt_chan.sv
// One 16-bit down/up counter with a reload register.
// Assumes count enable and loads come from the timer top.
`timescale 1ns/1ps
module gpt_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic up,
    input wire logic wr,
    input wire logic [15:0] wdata,
    input wire logic reload_now,
    // State
    output logic [15:0] count,
    output logic [15:0] reload,
    output logic wrap,
    output logic wrap_up
);
    wire at_end = up ? (count == gpt_pkg::CNT_ONES) : (count == gpt_pkg::CNT_ZERO);
    wire next_wrap = run & at_end & ~reload_now;

    // Reload register and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= gpt_pkg::CNT_RESET;
            reload <= gpt_pkg::CNT_RESET;
            wrap <= 1'b0;
            wrap_up <= 1'b0;
        end else begin
            wrap <= next_wrap;
            if (next_wrap) begin
                wrap_up <= up;
            end
            if (wr) begin
                reload <= wdata;
                if (!run) begin
                    count <= wdata;
                end
            end else if (reload_now || next_wrap) begin
                count <= reload;
            end else if (run) begin
                count <= up ? count + 16'h0001 : count - 16'h0001;
            end
        end
    end
endmodule // gpt_chan

// file: test/gpt_trig_model.sv
// Model of the external trigger source that drives the A channel trigger pin.
// Assumes pclk is the count source and that the pin is sampled on pclk.
`timescale 1ns/1ps
module gpt_trig_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Trigger pin towards the timer
    output logic a_trigger_input
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    int hold = 0; // Cycles left with the pin high
    int gap = 8; // Cycles since the last trigger edge
    initial a_trigger_input = 1'b0;

    // Pin falls back to its idle low level after a short pulse
    always @(posedge pclk) begin
        gap <= gap + 1;
        if (hold == 1) begin
            a_trigger_input <= 1'b0;
        end
        if (hold > 0) begin
            hold <= hold - 1;
        end
    end

    // Raise one trigger edge; returns at once so the bench can time the answer
    task automatic fire();
        // Move the pin only just after a rising edge
        @(posedge pclk);
        // Keep at least two count periods between trigger edges
        while (gap < 2 || hold > 0) begin
            @(posedge pclk);
        end
        a_trigger_input <= 1'b1;
        hold <= 3;
        gap <= 0;
    endtask
endmodule // gpt_trig_model

// file: test/general_purpose_timer_units_tb.sv
// Self-checking bench for the timer top: APB master tasks, expected reads
// worked out here, and pin checks. Assumes the trigger model in test/.
`timescale 1ns/1ps
module general_purpose_timer_units_tb;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, trig, pulse;
    logic [1:0] irq;
    logic [31:0] rd; // Data of the last read
    logic err_seen; // Error response of the last transfer
    logic [31:0] seed = 32'hc6e8_e71a; // Random state
    int num_errors = 0;
    int n_checks = 0;

    // Clock of 100 ns period
    always #50 pclk = ~pclk;

    gpt_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .a_trigger_input(trig),
        .a_pulse_output(pulse), .interrupt_request_flag(irq));
    gpt_trig_model trig_m (.pclk(pclk), .presetn(presetn), .a_trigger_input(trig));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Return mid-cycle so that pins and flags are read settled
        @(negedge pclk);
    endtask
    // Wait a bounded time for the pulse pin to reach a level
    task automatic wait_pin(input logic want, input int lim, input string what);
        int k;
        k = 0;
        while (pulse !== want && k < lim) begin
            @(negedge pclk);
            k++;
        end
        chk_bit(what, want, pulse);
    endtask
    // Run one channel freely and collect reads at random moments
    task automatic sweep(input int i);
        logic isb, up;
        logic [7:0] cofs;
        logic [15:0] rl, sp;
        int q[$];
        int hits;
        isb = (i > 2);
        up = (i == 2);
        cofs = isb ? gpt_pkg::OFS_B_CNT : gpt_pkg::OFS_A_CNT;
        rl = up ? 16'hFFF0 : 16'h0010;
        sp = up ? gpt_pkg::CNT_ZERO : gpt_pkg::CNT_ONES;
        hits = 0;
        apb(1'b1, gpt_pkg::OFS_UPDN, {31'h0000_0000, up});
        apb(1'b1, isb ? gpt_pkg::OFS_B_MODE : gpt_pkg::OFS_A_MODE,
            (i == 0 || i == 3) ? 32'h0000_0000 : 32'h0000_0001);
        apb(1'b1, cofs, {16'h0000, rl});
        apb(1'b0, cofs, 32'h0000_0000);
        chk_word("stopped readback", {16'h0000, rl}, rd);
        apb(1'b1, gpt_pkg::OFS_IRQ, 32'h0000_0003);
        apb(1'b1, gpt_pkg::OFS_START, isb ? 32'h0000_0002 : 32'h0000_0001);
        repeat (80) begin
            seed = lfsr(seed);
            repeat (seed[0]) @(posedge pclk);
            apb(1'b0, cofs, 32'h0000_0000);
            q.push_back(rd);
        end
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0000);
        // Each wrap of the running channel raises its request flag
        chk_bit("wrap flag", 1'b1, irq[isb]);
        // Live count lies between reload and end, or is the reload marker
        foreach (q[k]) begin
            hits += (q[k][15:0] === sp);
            chk_bit("count range", 1'b1, q[k][15:0] === sp ||
                (up ? q[k][15:0] >= rl : q[k][15:0] <= rl));
        end
        chk_bit("reload marker seen", 1'b1, hits > 0);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Watchdog against a hung handshake
    // --------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state: stopped, clear, pin low
        apb(1'b0, gpt_pkg::OFS_START, 32'h0000_0000);
        chk_word("start flags", 32'h0000_0000, rd);
        apb(1'b0, gpt_pkg::OFS_A_CNT, 32'h0000_0000);
        chk_word("a count", {16'h0000, gpt_pkg::CNT_RESET}, rd);
        chk_bit("a flag reset", 1'b0, irq[0]);
        chk_bit("pin reset", 1'b0, pulse);
        // Unmapped address is refused
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_word("unmapped read", gpt_pkg::RD_ZERO, rd);
        chk_bit("unmapped error", 1'b1, err_seen);
        // Random word into the stopped B counter, low half kept
        seed = lfsr(seed);
        apb(1'b1, gpt_pkg::OFS_B_CNT, seed);
        apb(1'b0, gpt_pkg::OFS_B_CNT, 32'h0000_0000);
        chk_word("b readback", {16'h0000, seed[15:0]}, rd);
        // One-shot entry after reset raises the flag
        apb(1'b1, gpt_pkg::OFS_A_MODE, 32'h0000_0002);
        chk_bit("oneshot entry flag", 1'b1, irq[0]);
        apb(1'b1, gpt_pkg::OFS_IRQ, 32'h0000_0003);
        chk_bit("flag cleared", 1'b0, irq[0]);
        // Software trigger, then stop in mid count
        apb(1'b1, gpt_pkg::OFS_A_CNT, 32'h0000_0028);
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0001);
        apb(1'b1, gpt_pkg::OFS_TRIG, 32'h0000_0001);
        wait_pin(1'b1, 3, "oneshot out high");
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0000);
        repeat (3) @(negedge pclk);
        chk_bit("stop pin low", 1'b0, pulse);
        chk_bit("stop flag", 1'b1, irq[0]);
        apb(1'b0, gpt_pkg::OFS_A_CNT, 32'h0000_0000);
        chk_word("stop reload", 32'h0000_0028, rd);
        // External trigger, then a retrigger well before zero
        apb(1'b1, gpt_pkg::OFS_A_MODE, 32'h0000_0006);
        apb(1'b1, gpt_pkg::OFS_A_CNT, 32'h0000_003C);
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0001);
        trig_m.fire();
        wait_pin(1'b1, 3, "ext trigger out");
        repeat (20) @(posedge pclk);
        trig_m.fire();
        repeat (4) @(posedge pclk);
        apb(1'b0, gpt_pkg::OFS_A_CNT, 32'h0000_0000);
        chk_bit("retrigger reload", 1'b1, rd <= 32'h0000_003C && rd >= 32'h0000_002D);
        chk_bit("retrigger keeps out", 1'b1, pulse);
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0000);
        // Timer mode, then into PWM: flag raised
        apb(1'b1, gpt_pkg::OFS_A_MODE, 32'h0000_0000);
        apb(1'b1, gpt_pkg::OFS_IRQ, 32'h0000_0003);
        apb(1'b1, gpt_pkg::OFS_A_MODE, 32'h0000_0003);
        chk_bit("pwm entry flag", 1'b1, irq[0]);
        apb(1'b1, gpt_pkg::OFS_A_CNT, 32'h0000_0014);
        // Stop while the output is high
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0001);
        // The pulse window opens on a trigger once started
        apb(1'b1, gpt_pkg::OFS_TRIG, 32'h0000_0001);
        wait_pin(1'b1, 50, "pwm high");
        apb(1'b1, gpt_pkg::OFS_IRQ, 32'h0000_0003);
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0000);
        repeat (3) @(negedge pclk);
        chk_bit("pwm stop high pin", 1'b0, pulse);
        chk_bit("pwm stop high flag", 1'b1, irq[0]);
        // Stop while the output is low: nothing changes
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0001);
        apb(1'b1, gpt_pkg::OFS_TRIG, 32'h0000_0001);
        wait_pin(1'b1, 50, "pwm high again");
        wait_pin(1'b0, 50, "pwm low");
        apb(1'b1, gpt_pkg::OFS_IRQ, 32'h0000_0003);
        apb(1'b1, gpt_pkg::OFS_START, 32'h0000_0000);
        repeat (25) @(negedge pclk);
        chk_bit("pwm stop low pin", 1'b0, pulse);
        chk_bit("pwm stop low flag", 1'b0, irq[0]);
        // Free-running reads in timer and event modes of both channels
        for (int i = 0; i < 5; i++) begin
            sweep(i);
        end
        final_report();
    end
endmodule // general_purpose_timer_units_tb
